// [rtl/buck_boost_mode_and_softstart_ctrl.sv]
// bridge mode selection, switch drive and adapter soft-start sequencer
`timescale 1ns/1ps
`include "charger_defs.svh"

module buck_boost_mode_and_softstart_ctrl #(
    parameter int COUNT_W = 24,
    parameter int unsigned DEB_LONG_CYC = `DEB_LONG_CYC,
    parameter int unsigned DEB_SHORT_CYC = `DEB_SHORT_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic biasAbove2v7,
    input wire logic biasAbove3v8,
    input wire logic adapterAbove3v2,
    input wire logic adapterAbove94,
    input wire logic adapterAbove120,
    input wire logic adapterAbove106,
    input wire logic adapterAbove80,
    input wire logic batteryAbove5v8,
    input wire logic inputSenseAbove2v,
    input wire logic adapterDetectAbove0v8,
    input wire logic otgEnablePin,
    input wire logic turboEvent,
    input wire logic phaseZero,
    input wire logic rippleAtWindow,
    input wire logic rippleAtComp,
    input wire logic adapterGateFull,
    input wire logic otgCommand,
    input wire logic singleCell,
    input wire logic longDebounce,
    input wire logic sysPowerMonitorEn,
    input wire logic diodeEmulation,
    input wire logic [3:0] configResistorCode,
    output logic inputHighSwitch,
    output logic inputLowSwitch,
    output logic outputLowSwitch,
    output logic outputHighSwitch,
    output logic adapterGate,
    output logic batteryGate,
    output logic adapterGoodOut,
    output logic adapterGoodOe,
    output logic configSourceEn,
    output logic [3:0] configCode,
    output logic [1:0] opMode,
    output logic busReady,
    output logic lowPower
);
    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [15:0] syncOut;
    logic sBias27, sBias38, sAdp32, sA94, sA120, sA106, sA80, sBat58;
    logic sSense2v, sDetect, sOtgPin, sTurbo, sPhz, sWindow, sComp, sGateFull;

    sync_bits #(.WIDTH(16)) inSync (
        .clk(clk),
        .nrst(nrst),
        .din({biasAbove2v7, biasAbove3v8, adapterAbove3v2, adapterAbove94, adapterAbove120,
            adapterAbove106, adapterAbove80, batteryAbove5v8, inputSenseAbove2v,
            adapterDetectAbove0v8, otgEnablePin, turboEvent, phaseZero, rippleAtWindow,
            rippleAtComp, adapterGateFull}),
        .dout(syncOut)
    );

    assign {sBias27, sBias38, sAdp32, sA94, sA120, sA106, sA80, sBat58, sSense2v,
        sDetect, sOtgPin, sTurbo, sPhz, sWindow, sComp, sGateFull} = syncOut;

    // ---------------------------------------------------------------
    // soft-start sequencer
    // ---------------------------------------------------------------
    charger_pkg::seq_t state, next_state;
    logic [COUNT_W-1:0] count, next_count;
    logic firstPlug, next_firstPlug;
    logic [3:0] next_configCode;
    logic shortNow;
    logic goodReady;

    assign shortNow = !sSense2v || !sDetect;
    assign goodReady = sBias38 && sDetect && sGateFull;

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_firstPlug = firstPlug;
        next_configCode = configCode;
        unique case (state)
            charger_pkg::SEQ_OFF:
            begin
                if (sBias27)
                    next_state = charger_pkg::SEQ_WAIT;
            end
            charger_pkg::SEQ_WAIT:
            begin
                if (sAdp32)
                begin
                    next_state = charger_pkg::SEQ_DEBOUNCE;
                    // first plug after power-on always takes the short wait
                    if (longDebounce && !firstPlug)
                        next_count = COUNT_W'(DEB_LONG_CYC - 1);
                    else
                        next_count = COUNT_W'(DEB_SHORT_CYC - 1);
                end
            end
            charger_pkg::SEQ_DEBOUNCE:
            begin
                if (!sAdp32)
                    next_state = charger_pkg::SEQ_WAIT;
                else if (shortNow)
                    next_count = COUNT_W'(DEB_SHORT_CYC - 1);
                else if (count == '0)
                begin
                    next_state = charger_pkg::SEQ_CFGREAD;
                    next_firstPlug = 1'b0;
                    next_count = COUNT_W'(`CFG_SETTLE_CYC - 1);
                end
                else
                    next_count = count - COUNT_W'(1);
            end
            charger_pkg::SEQ_CFGREAD:
            begin
                // the pin needs its rc time to settle before it is sampled
                if (!sAdp32)
                    next_state = charger_pkg::SEQ_WAIT;
                else if (count == '0)
                begin
                    next_configCode = configResistorCode;
                    next_state = charger_pkg::SEQ_GATEON;
                end
                else
                    next_count = count - COUNT_W'(1);
            end
            charger_pkg::SEQ_GATEON:
            begin
                if (!sAdp32 || !sDetect)
                    next_state = charger_pkg::SEQ_WAIT;
                else if (goodReady)
                    next_state = charger_pkg::SEQ_RUN;
            end
            charger_pkg::SEQ_RUN:
            begin
                if (!sAdp32 || !sDetect)
                    next_state = charger_pkg::SEQ_WAIT;
                else if (!goodReady)
                    next_state = charger_pkg::SEQ_GATEON;
            end
            default:
                next_state = charger_pkg::SEQ_OFF;
        endcase
        if (!sBias27)
            next_state = charger_pkg::SEQ_OFF;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= charger_pkg::SEQ_OFF;
            count <= '0;
            firstPlug <= 1'b1;
            configCode <= 4'h0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            firstPlug <= next_firstPlug;
            configCode <= next_configCode;
        end
    end

    assign busReady = (state != charger_pkg::SEQ_OFF);
    assign configSourceEn = (state == charger_pkg::SEQ_CFGREAD);
    assign adapterGate = (state == charger_pkg::SEQ_GATEON) || (state == charger_pkg::SEQ_RUN);
    // open drain: pulled low unless fully ready
    assign adapterGoodOut = 1'b0;
    assign adapterGoodOe = (state != charger_pkg::SEQ_RUN);
    assign lowPower = (state == charger_pkg::SEQ_WAIT) && !sysPowerMonitorEn;

    // ---------------------------------------------------------------
    // operating mode selection
    // ---------------------------------------------------------------
    charger_pkg::mode_t mode, next_mode;
    logic otgOk;

    // otg only with no adapter attached, from battery
    assign otgOk = otgCommand && sOtgPin && sBat58 && !singleCell
        && (state == charger_pkg::SEQ_WAIT);

    always_comb
    begin
        next_mode = mode;
        if (otgOk)
            next_mode = charger_pkg::MODE_OTG;
        else
        begin
            unique case (mode)
                charger_pkg::MODE_BOOST:
                begin
                    if (sA120)
                        next_mode = charger_pkg::MODE_BUCK;
                    else if (sA94)
                        next_mode = charger_pkg::MODE_BUCKBOOST;
                end
                charger_pkg::MODE_BUCKBOOST:
                begin
                    if (sA120)
                        next_mode = charger_pkg::MODE_BUCK;
                    else if (!sA80)
                        next_mode = charger_pkg::MODE_BOOST;
                end
                charger_pkg::MODE_BUCK:
                begin
                    if (!sA106)
                        next_mode = charger_pkg::MODE_BUCKBOOST;
                end
                charger_pkg::MODE_OTG:
                    next_mode = charger_pkg::MODE_BUCKBOOST;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mode <= charger_pkg::MODE_BUCK;
        else
            mode <= next_mode;
    end

    assign opMode = mode;

    // ---------------------------------------------------------------
    // pwm, diode emulation and switch drive
    // ---------------------------------------------------------------
    logic swEn;
    logic pwmOn, next_pwmOn;
    logic syncCut, next_syncCut;
    logic ctrlOn, syncOn;
    logic next_ih, next_il, next_ol, next_oh, next_battery_gate;

    assign swEn = (state == charger_pkg::SEQ_RUN) || (mode == charger_pkg::MODE_OTG);
    assign ctrlOn = pwmOn;
    assign syncOn = !pwmOn && !syncCut;

    always_comb
    begin
        next_pwmOn = pwmOn;
        next_syncCut = syncCut;
        if (!swEn)
            next_pwmOn = 1'b0;
        else if (pwmOn && sWindow)
            next_pwmOn = 1'b0;
        else if (!pwmOn && sComp)
            next_pwmOn = 1'b1;
        // low side stays off until the next on-pulse
        if (next_pwmOn)
            next_syncCut = 1'b0;
        else if (diodeEmulation && sPhz)
            next_syncCut = 1'b1;
        next_ih = 1'b0;
        next_il = 1'b0;
        next_ol = 1'b0;
        next_oh = 1'b0;
        if (swEn)
        begin
            unique case (mode)
                charger_pkg::MODE_BUCK:
                begin
                    next_ih = ctrlOn;
                    next_il = syncOn;
                    next_oh = 1'b1;
                end
                charger_pkg::MODE_BOOST:
                begin
                    next_ih = 1'b1;
                    next_ol = ctrlOn;
                    next_oh = syncOn;
                end
                charger_pkg::MODE_BUCKBOOST:
                begin
                    next_ih = ctrlOn;
                    next_ol = ctrlOn;
                    next_il = syncOn;
                    next_oh = syncOn;
                end
                charger_pkg::MODE_OTG:
                begin
                    next_ih = 1'b1;
                    next_oh = ctrlOn;
                    next_ol = syncOn;
                end
            endcase
        end
        // battery feeds the system when alone, in otg, or on turbo
        next_battery_gate = sTurbo || (state == charger_pkg::SEQ_WAIT)
            || (state == charger_pkg::SEQ_OFF) || (mode == charger_pkg::MODE_OTG);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pwmOn <= 1'b0;
            syncCut <= 1'b0;
            inputHighSwitch <= 1'b0;
            inputLowSwitch <= 1'b0;
            outputLowSwitch <= 1'b0;
            outputHighSwitch <= 1'b0;
            batteryGate <= 1'b0;
        end
        else
        begin
            pwmOn <= next_pwmOn;
            syncCut <= next_syncCut;
            inputHighSwitch <= next_ih;
            inputLowSwitch <= next_il;
            outputLowSwitch <= next_ol;
            outputHighSwitch <= next_oh;
            batteryGate <= next_battery_gate;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_buck_fixed: assert property ((swEn && mode == charger_pkg::MODE_BUCK) |=>
        (!outputLowSwitch && outputHighSwitch && inputHighSwitch == $past(pwmOn)))
        else $error("buck switch pattern wrong");
    a_boost_fixed: assert property ((swEn && mode == charger_pkg::MODE_BOOST) |=>
        (inputHighSwitch && !inputLowSwitch && outputLowSwitch == $past(pwmOn)))
        else $error("boost switch pattern wrong");
    a_bb_pairs: assert property ((swEn && mode == charger_pkg::MODE_BUCKBOOST) |=>
        (inputHighSwitch == outputLowSwitch && inputLowSwitch == outputHighSwitch))
        else $error("buck-boost pairs not together");
    a_otg_fixed: assert property (mode == charger_pkg::MODE_OTG |=>
        (inputHighSwitch && !inputLowSwitch && outputHighSwitch == $past(pwmOn)))
        else $error("otg switch pattern wrong");
    a_rise_bb: assert property ((mode == charger_pkg::MODE_BOOST && sA94 && !sA120 && !otgOk)
        |=> mode == charger_pkg::MODE_BUCKBOOST)
        else $error("boost did not go to buck-boost");
    a_force_buck: assert property ((mode == charger_pkg::MODE_BUCKBOOST && sA120 && !otgOk)
        |=> mode == charger_pkg::MODE_BUCK)
        else $error("forced buck missed");
    a_fall_bb: assert property ((mode == charger_pkg::MODE_BUCK && !sA106 && !otgOk)
        |=> mode == charger_pkg::MODE_BUCKBOOST)
        else $error("buck did not go to buck-boost");
    a_fall_boost: assert property ((mode == charger_pkg::MODE_BUCKBOOST && !sA80 && !sA120 && !otgOk)
        |=> mode == charger_pkg::MODE_BOOST)
        else $error("buck-boost did not go to boost");
    a_otg_entry: assert property (mode == charger_pkg::MODE_OTG |->
        $past(otgCommand && sOtgPin && sBat58))
        else $error("otg without its conditions");
    a_otg_cells: assert property (mode == charger_pkg::MODE_OTG |-> $past(!singleCell))
        else $error("otg with single cell");
    a_turbo_gate: assert property (sTurbo |=> batteryGate)
        else $error("turbo did not close battery gate");
    a_bias_off: assert property (!sBias27 |=> (!busReady && !adapterGate))
        else $error("logic active without bias");
    a_first_short: assert property ((state == charger_pkg::SEQ_WAIT && sAdp32 && sBias27 && firstPlug)
        |=> (state == charger_pkg::SEQ_DEBOUNCE && count == COUNT_W'(DEB_SHORT_CYC - 1)))
        else $error("first plug debounce not short");
    a_short_hold: assert property ((state == charger_pkg::SEQ_DEBOUNCE && shortNow)
        |=> (!adapterGate && state != charger_pkg::SEQ_CFGREAD))
        else $error("gate sequence advanced on short");
    a_good_release: assert property (!adapterGoodOe |-> $past(sBias38 && sDetect && sGateFull))
        else $error("adapter good released early");
    a_switch_after: assert property ($rose(pwmOn) |->
        $past(state == charger_pkg::SEQ_RUN || mode == charger_pkg::MODE_OTG))
        else $error("switching before adapter good");
    a_good_low: assert property ((!sDetect && sBias27) |=> (adapterGoodOe && !adapterGoodOut))
        else $error("adapter good not pulled low");
    a_cfg_first: assert property ($rose(adapterGate) |->
        ($past(state == charger_pkg::SEQ_CFGREAD) && $past(count == '0)))
        else $error("gate on before config read");
    a_de_cut: assert property ((diodeEmulation && sPhz && !next_pwmOn) |=> syncCut)
        else $error("low side not cut at zero");
    a_pwm_end: assert property ((pwmOn && sWindow) |=> !pwmOn)
        else $error("pulse did not end at window");

    c_run: cover property (state == charger_pkg::SEQ_GATEON ##1 state == charger_pkg::SEQ_RUN);
    c_otg: cover property (mode == charger_pkg::MODE_OTG && pwmOn);
    c_bb_to_buck: cover property (mode == charger_pkg::MODE_BUCKBOOST ##1 mode == charger_pkg::MODE_BUCK);
    c_de: cover property ($rose(syncCut));
endmodule // buck_boost_mode_and_softstart_ctrl

// [rtl/charger_defs.svh]
// timing constants of the charger sequencer
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH

// ---------------------------------------------------------------
// clock
// ---------------------------------------------------------------
`define CLK_HZ 10_000_000
`define CLK_PERIOD_NS 100

// ---------------------------------------------------------------
// adapter debounce times, in milliseconds
// ---------------------------------------------------------------
`define DEB_LONG_MS 1300
`define DEB_SHORT_MS 150
`define DEB_LONG_CYC (`DEB_LONG_MS * (`CLK_HZ / 1000))
`define DEB_SHORT_CYC (`DEB_SHORT_MS * (`CLK_HZ / 1000))

// ---------------------------------------------------------------
// settle time of the config resistor pin before it is sampled
// ---------------------------------------------------------------
`define CFG_SETTLE_NS 40_000
`define CFG_SETTLE_CYC ((`CFG_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/charger_pkg.sv]
// types shared by the charger control logic
package charger_pkg;

    // -----------------------------------------------------------
    // bridge operating mode, as reported on the status field
    // -----------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_BUCK = 2'h0,
        MODE_BOOST = 2'h1,
        MODE_BUCKBOOST = 2'h2,
        MODE_OTG = 2'h3
    } mode_t;

    // -----------------------------------------------------------
    // soft-start sequencer states
    // -----------------------------------------------------------
    typedef enum logic [2:0] {
        SEQ_OFF = 3'h0,
        SEQ_WAIT = 3'h1,
        SEQ_DEBOUNCE = 3'h2,
        SEQ_CFGREAD = 3'h3,
        SEQ_GATEON = 3'h4,
        SEQ_RUN = 3'h5
    } seq_t;

endpackage

// [rtl/sync_bits.sv]
// two-flop synchroniser for a group of independent level inputs
`timescale 1ns/1ps

module sync_bits #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    // each bit is an independent level; no word coherence is implied
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1 <= '0;
            dout <= '0;
        end
        else
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule // sync_bits

// [verification/bridge_model.sv]
// model of the external bridge and its analog comparators
`timescale 1ns/1ps
module bridge_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic buckLike,
    input wire logic ih,
    input wire logic il,
    input wire logic ol,
    input wire logic oh,
    input wire logic gateOn,
    output logic atWindow,
    output logic atComp,
    output logic zero,
    output logic gateFull
);
    int level = 0;
    int lowCnt = 0;
    int gateCnt = 0;
    // ripple mimics coil current; buck on-time and boost off-time look alike at the gates, so the bench says which
    always @(posedge clk)
    begin
        if (ol || (buckLike && ih && !il && oh))
            level <= level + 1;
        else if (level > 0)
            level <= level - 1;
        lowCnt <= (il || ol) ? lowCnt + 1 : 0;
        gateCnt <= gateOn ? gateCnt + 1 : 0;
    end
    assign atWindow = level >= (slow ? 30 : 6);
    assign atComp = level == 0;
    assign zero = lowCnt >= 3;
    assign gateFull = gateCnt >= (slow ? 40 : 5);
endmodule // bridge_model

// [verification/testbench.sv]
// self-checking bench of the charger mode and soft-start control
`timescale 1ns/1ps
module testbench;
    typedef struct {int sel; logic [3:0] exp;} note_t;
    localparam logic [5:0] ROWS [7] = '{6'h3c, 6'h06, 6'h01, 6'h26, 6'h3c, 6'h01, 6'h3c};
    logic clk = 1'h0, nrst = 1'h0, slow, buckLike;
    logic biasAbove2v7, biasAbove3v8, adapterAbove3v2, adapterAbove94, adapterAbove120, adapterAbove106;
    logic adapterAbove80, batteryAbove5v8, inputSenseAbove2v, adapterDetectAbove0v8, otgEnablePin;
    logic turboEvent, otgCommand, singleCell, longDebounce, sysPowerMonitorEn, diodeEmulation;
    logic phaseZero, rippleAtWindow, rippleAtComp, adapterGateFull, inputHighSwitch, inputLowSwitch;
    logic outputLowSwitch, outputHighSwitch, adapterGate, batteryGate, adapterGoodOut, adapterGoodOe;
    logic configSourceEn, busReady, lowPower;
    logic [3:0] configResistorCode, configCode, measured;
    logic [1:0] opMode;
    int badCount = 0, checkCount = 0, waited, seed, rnd;
    note_t notes[$];
    note_t cur;
    event lookEv;
    always #50 clk = ~clk;
    buck_boost_mode_and_softstart_ctrl #(.DEB_LONG_CYC(20), .DEB_SHORT_CYC(8)) DUT (.clk, .nrst,
        .biasAbove2v7, .biasAbove3v8, .adapterAbove3v2, .adapterAbove94, .adapterAbove120, .adapterAbove106,
        .adapterAbove80, .batteryAbove5v8, .inputSenseAbove2v, .adapterDetectAbove0v8, .otgEnablePin,
        .turboEvent, .phaseZero, .rippleAtWindow, .rippleAtComp, .adapterGateFull, .otgCommand, .singleCell,
        .longDebounce, .sysPowerMonitorEn, .diodeEmulation, .configResistorCode, .inputHighSwitch,
        .inputLowSwitch, .outputLowSwitch, .outputHighSwitch, .adapterGate, .batteryGate, .adapterGoodOut,
        .adapterGoodOe, .configSourceEn, .configCode, .opMode, .busReady, .lowPower);
    bridge_model partner (.clk, .slow, .buckLike, .ih(inputHighSwitch), .il(inputLowSwitch),
        .ol(outputLowSwitch), .oh(outputHighSwitch), .gateOn(adapterGate), .atWindow(rippleAtWindow),
        .atComp(rippleAtComp), .zero(phaseZero), .gateFull(adapterGateFull));
    // selector 9 is a value the driver worked out itself
    function automatic logic [3:0] obs(input int sel);
        case (sel)
            0: return {2'h0, opMode};
            1: return configCode;
            2: return {inputHighSwitch, inputLowSwitch, outputLowSwitch, outputHighSwitch};
            3: return {3'h0, adapterGate};
            4: return {3'h0, adapterGoodOe};
            5: return {3'h0, busReady};
            6: return {3'h0, batteryGate};
            7: return {3'h0, configSourceEn};
            8: return {3'h0, lowPower};
            9: return measured;
            10: return {3'h0, inputHighSwitch};
            11: return {3'h0, inputLowSwitch};
            12: return {3'h0, outputLowSwitch};
            default: return {3'h0, adapterGoodOut};
        endcase
    endfunction
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            badCount++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic expect_now(input int sel, input logic [3:0] exp);
        notes.push_back('{sel, exp});
        -> lookEv;
        // let the checker look before the driver moves any input
        #0;
    endtask
    task automatic skip(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait; measured tells whether the wait fell inside lo..hi
    task automatic timed(input int sel, input logic [3:0] val, input int lo, input int hi);
        waited = 0;
        while (obs(sel) !== val && waited < 1000)
        begin
            @(negedge clk);
            waited++;
        end
        measured = {3'h0, waited >= lo && waited <= hi};
    endtask
    task automatic stopTest();
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        forever
        begin
            @(lookEv);
            while (notes.size() > 0)
            begin
                cur = notes.pop_front();
                check(obs(cur.sel), cur.exp);
            end
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        badCount++;
        $display("mismatch at %0t: watchdog expired", $time);
        stopTest();
    end
    initial
    begin
        {biasAbove2v7, biasAbove3v8, adapterAbove3v2, batteryAbove5v8, inputSenseAbove2v, otgEnablePin} = '0;
        {adapterDetectAbove0v8, turboEvent, otgCommand, singleCell, longDebounce} = '0;
        {sysPowerMonitorEn, diodeEmulation, measured} = '0;
        {adapterAbove94, adapterAbove120, adapterAbove106, adapterAbove80, slow, buckLike} = 6'h3f;
        seed = 32'h48ef_9310;
        rnd = $random(seed);
        configResistorCode = rnd[3:0];
        skip(6);
        nrst = 1'h1;
        skip(2);
        expect_now(5, 4'h0);
        biasAbove2v7 = 1'h1;
        skip(5);
        expect_now(5, 4'h1);
        // synchronisers leave reset low, so the mode wanders until they fill
        expect_now(0, 4'h0);
        expect_now(8, 4'h1);
        sysPowerMonitorEn = 1'h1;
        skip(2);
        expect_now(8, 4'h0);
        $display("test power-up done");
        for (int k = 0; k < 16; k++)
        begin
            {otgCommand, otgEnablePin, batteryAbove5v8, singleCell} = k[3:0];
            skip(6);
            measured = {3'h0, opMode === charger_pkg::MODE_OTG};
            expect_now(9, {3'h0, k == 14});
        end
        {otgCommand, otgEnablePin, batteryAbove5v8, singleCell} = 4'h0;
        foreach (ROWS[i])
        begin
            {adapterAbove94, adapterAbove120, adapterAbove106, adapterAbove80} = ROWS[i][5:2];
            skip(6);
            expect_now(0, {2'h0, ROWS[i][1:0]});
        end
        $display("test mode selection done");
        {longDebounce, adapterDetectAbove0v8, inputSenseAbove2v, adapterAbove3v2} = 4'hf;
        timed(7, 4'h1, 9, 14);
        expect_now(9, 4'h1);
        expect_now(3, 4'h0);
        timed(3, 4'h1, 0, 1000);
        expect_now(7, 4'h0);
        expect_now(1, rnd[3:0]);
        expect_now(2, 4'h0);
        skip(60);
        expect_now(4, 4'h1);
        biasAbove3v8 = 1'h1;
        timed(4, 4'h0, 0, 6);
        expect_now(9, 4'h1);
        expect_now(13, 4'h0);
        timed(10, 4'h1, 0, 1000);
        expect_now(2, 4'h9);
        timed(11, 4'h1, 0, 1000);
        expect_now(2, 4'h5);
        expect_now(6, 4'h0);
        turboEvent = 1'h1;
        skip(4);
        expect_now(6, 4'h1);
        {turboEvent, diodeEmulation} = 2'h1;
        timed(10, 4'h1, 0, 1000);
        timed(11, 4'h1, 0, 1000);
        skip(12);
        expect_now(2, 4'h1);
        {diodeEmulation, slow} = 2'h0;
        {adapterAbove94, adapterAbove120, adapterAbove106, adapterAbove80} = 4'h9;
        skip(6);
        timed(12, 4'h1, 0, 1000);
        expect_now(2, 4'ha);
        timed(12, 4'h0, 0, 1000);
        expect_now(2, 4'h5);
        {adapterAbove94, adapterAbove80, buckLike} = 3'h0;
        skip(6);
        timed(12, 4'h1, 0, 1000);
        expect_now(2, 4'ha);
        timed(12, 4'h0, 0, 1000);
        expect_now(2, 4'h9);
        $display("test run and switching done");
        {adapterAbove94, adapterAbove120, adapterAbove106, adapterAbove80, buckLike} = 5'h1f;
        adapterDetectAbove0v8 = 1'h0;
        timed(4, 4'h1, 0, 6);
        expect_now(9, 4'h1);
        skip(4);
        expect_now(2, 4'h0);
        adapterAbove3v2 = 1'h0;
        skip(6);
        {inputSenseAbove2v, adapterDetectAbove0v8, adapterAbove3v2} = 3'h3;
        skip(60);
        expect_now(7, 4'h0);
        inputSenseAbove2v = 1'h1;
        timed(7, 4'h1, 9, 14);
        expect_now(9, 4'h1);
        adapterAbove3v2 = 1'h0;
        skip(6);
        adapterAbove3v2 = 1'h1;
        timed(7, 4'h1, 21, 26);
        expect_now(9, 4'h1);
        biasAbove2v7 = 1'h0;
        skip(5);
        expect_now(5, 4'h0);
        $display("test replug and power-down done");
        skip(2);
        stopTest();
    end
endmodule // testbench
